// ==== testbench/ihap_far_model.sv ====
`timescale 1ns/10ps
// Far-side model: indirect memories and connection blocks answering the port.
module ihap_far_model (
   // Clock, reset and answer delay.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [5:0] pace,
   // Memory side.
   input wire logic mem_rd,
   input wire logic [11:0] mem_addr,
   output logic mem_ack,
   output logic [7:0] mem_rdata,
   // Command side.
   input wire logic cam_req,
   input wire ihap_pkg::ihap_blk_t cam_blk,
   output logic cam_done,
   output logic [7:0] cam_result
);
   import ihap_pkg::*;
   logic [6:0] mcnt_r, ccnt_r; // Cycles left until each answer.
   logic [7:0] mval_r, cval_r; // Answers waiting to be given.
   // Each answer comes pace+2 cycles after its request; data lines toggle otherwise.
   always_ff @(posedge clock) begin
      mem_ack <= (mcnt_r == 7'h01);
      cam_done <= (ccnt_r == 7'h01);
      mem_rdata <= (mcnt_r == 7'h01) ? mval_r : ~mem_rdata;
      cam_result <= (ccnt_r == 7'h01) ? cval_r : ~cam_result;
      mcnt_r <= mem_rd ? {1'b0, pace} + 7'h01 : mcnt_r - (mcnt_r != 7'h00);
      ccnt_r <= cam_req ? {1'b0, pace} + 7'h01 : ccnt_r - (ccnt_r != 7'h00);
      mval_r <= mem_rd ? (mem_addr[7:0] ^ 8'h5A) : mval_r;
      cval_r <= cam_req ? (8'h30 + {6'h00, cam_blk}) : cval_r;
      if (!rst_n) begin
         mcnt_r <= 7'h00;
         ccnt_r <= 7'h00;
         mem_rdata <= 8'h00;
         cam_result <= 8'h00;
      end
   end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
// Self-checking bench of the host access port.
module tb_top;
   import ihap_pkg::*;
   localparam int CLR = 6; // Self-clear length, longer than the default of 4.
   logic clock, rst_n, cs_n, rd_n, wr_n, data_oe, mem_wr, mem_rd, mem_ack, cam_req, cam_done;
   logic local_hold_reset, software_reset, clock_fault_clear, system_fault_clear;
   logic active_buffer, main_bus_output_enable, local_output_enable, local_function_enable;
   logic test_clock_enable;
   logic [1:0] addr;
   logic [7:0] data_in, data_out, mem_wdata, mem_rdata, cam_result, wd_r, sl, d, m;
   logic [11:0] mem_addr, ma_r;
   logic [5:0] pace;
   ihap_tgt_t mem_sel, ms_r;
   ihap_op_t cam_op, co_r, e;
   ihap_blk_t cam_blk, cb_r;
   int err_total, n_checks, nreq, nhr, nsw, ncf, nsf, bad, cyc, n0;
   logic [7:0] mtab [10] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h50, 8'h90, 8'hA0, 8'hB0, 8'hB1, 8'hB2};
   ihap_tgt_t ttab [10] = '{IHAP_TGT_CTRL, IHAP_TGT_LDM1, IHAP_TGT_LDM2, IHAP_TGT_LCMTS,
      IHAP_TGT_LCMSC, IHAP_TGT_CDM1, IHAP_TGT_CDM2, IHAP_TGT_CCMTS, IHAP_TGT_CCMSC,
      IHAP_TGT_CCMTAG};
   ihap_port #(.CLR_CYCLES(CLR)) i_dut (.clock, .rst_n, .cs_n, .rd_n, .wr_n, .addr, .data_in,
      .data_out, .data_oe, .mem_sel, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_ack,
      .mem_rdata, .cam_op, .cam_blk, .cam_req, .cam_done, .cam_result, .local_hold_reset,
      .software_reset, .clock_fault_clear, .system_fault_clear, .active_buffer,
      .main_bus_output_enable, .local_output_enable, .local_function_enable, .test_clock_enable);
   ihap_far_model i_far (.clock, .rst_n, .pace, .mem_rd, .mem_addr, .mem_ack, .mem_rdata,
      .cam_req, .cam_blk, .cam_done, .cam_result);
   // Clock generator.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Captures far-side requests, counts pulse lengths and cuts a hang short.
   always @(posedge clock) begin
      cyc++;
      if (mem_rd) ms_r <= mem_sel;
      if (mem_rd) ma_r <= mem_addr;
      if (mem_wr) wd_r <= mem_wdata;
      if (cam_req) co_r <= cam_op;
      if (cam_req) cb_r <= cam_blk;
      nreq += cam_req;
      nhr += local_hold_reset;
      nsw += software_reset;
      ncf += clock_fault_clear;
      nsf += system_fault_clear;
      bad += software_reset & (test_clock_enable | main_bus_output_enable | local_output_enable);
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // Compares one byte and reports a mismatch.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Host write: strobe held five cycles, address and data kept well past the take.
   task automatic hw(input int a, input logic [7:0] v);
      @(negedge clock);
      addr = 2'(a);
      data_in = v;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (5) @(negedge clock);
      wr_n = 1'b1;
      repeat (6) @(negedge clock);
      cs_n = 1'b1;
      data_in = ~v;
   endtask
   // Host read: sampled once the synchronised strobe has reached the output.
   task automatic hr(input int a, input logic [7:0] exp);
      @(negedge clock);
      addr = 2'(a);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (5) @(negedge clock);
      chk(data_out, exp);
      chk({7'h00, data_oe}, 8'h01);
      rd_n = 1'b1;
      cs_n = 1'b1;
   endtask
   // Expected command for a mode byte; reserved codes give none.
   function automatic ihap_op_t exp_op(input logic [7:0] c);
      if (c == 8'hFF) return IHAP_OP_INIT;
      if (c == 8'hFC) return IHAP_OP_RSTHOLD;
      if (c[1:0] == 2'h2 || c[7:5] != 3'h7) return IHAP_OP_NONE;
      if (c[4]) return c[2] ? IHAP_OP_NONE : (c[3] ? IHAP_OP_RSTBLK : IHAP_OP_FIND);
      return c[3] ? (c[2] ? IHAP_OP_READ : IHAP_OP_CLEAR) : (c[2] ? IHAP_OP_BREAK : IHAP_OP_MAKE);
   endfunction
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence.
   initial begin
      {cs_n, rd_n, wr_n, rst_n, addr, data_in, pace} = {3'b111, 1'b0, 2'h0, 8'h00, 6'h03};
      void'($urandom(386));
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      for (int a = 0; a < 4; a++) hr(a[1:0], 8'h00);
      chk({6'h00, test_clock_enable, main_bus_output_enable}, 8'h02);
      hw(0, 8'h1E);
      hr(0, 8'h1E);
      chk({4'h0, active_buffer, main_bus_output_enable, local_output_enable,
         local_function_enable}, 8'h0F);
      hw(0, 8'h9E);
      hr(0, 8'h00);
      hw(0, 8'h60);
      hr(0, 8'h00);
      chk(8'(nsw), 8'(CLR));
      chk(8'(bad), 8'h00);
      chk(8'(ncf), 8'(CLR));
      chk(8'(nsf), 8'(CLR));
      $display("test control done");
      hw(2, 8'h70);
      chk(8'(nhr), 8'h01);
      for (int i = 0; i < 10; i++) begin
         sl = 8'($urandom);
         m = mtab[i] | ((i > 0 && i < 5) ? 8'($urandom % 16) : 8'h00);
         pace = 6'($urandom % 5);
         hw(1, sl);
         hw(2, m);
         chk({4'h0, ms_r}, {4'h0, ttab[i]});
         chk(ma_r[11:4], {m[3:0], sl[7:4]});
         chk(ma_r[7:0], sl);
         hr(3, sl ^ 8'h5A);
         d = 8'($urandom);
         hw(3, d);
         chk(wd_r, d);
      end
      $display("test memory done");
      for (int c = 8'hE0; c <= 8'hFF; c++) begin
         n0 = nreq;
         e = exp_op(c[7:0]);
         hw(2, c[7:0]);
         repeat (10) @(negedge clock);
         chk(8'(nreq - n0), {7'h00, e != IHAP_OP_NONE});
         if (e != IHAP_OP_NONE) chk({4'h0, co_r}, {4'h0, e});
         if (e != IHAP_OP_NONE && c[7:0] < 8'hFC) chk({6'h00, cb_r}, {6'h00, c[1:0]});
         if (e == IHAP_OP_READ || e == IHAP_OP_FIND) hr(3, 8'h30 + {6'h00, c[1:0]});
      end
      $display("test commands done");
      pace = 6'h28;
      hw(2, 8'hF0);
      hr(0, 8'h01);
      repeat (50) @(negedge clock);
      hr(0, 8'h00);
      $display("test busy done");
      complete_run();
   end
endmodule

// ==== verilog/ihap_mode_decode.sv ====
`timescale 1ns/10ps
`include "ihap_regs.svh"
// Decodes the address mode register into a memory space or a command.
module ihap_mode_decode (
   // Address mode value.
   input wire logic [7:0] mode,
   // Decoded selections.
   output ihap_pkg::ihap_tgt_t tgt,
   output ihap_pkg::ihap_op_t op,
   output ihap_pkg::ihap_blk_t blk,
   output logic hold_reset
);
   import ihap_pkg::*;
   logic [3:0] up; // Space or command group.
   logic [3:0] lo; // Stream address or sub-code.
   logic lo_zero; // Lower nibble is all zero.
   logic blk_ok; // Lower two bits name a real block.

   assign up = mode[7:4];
   assign lo = mode[3:0];
   assign lo_zero = (lo == 4'h0);
   assign blk_ok = (lo[1:0] != 2'h2);

   // Reserved codes fall through to no target and no command.
   always_comb begin
      tgt = IHAP_TGT_NONE;
      op = IHAP_OP_NONE;
      blk = ihap_blk_t'(lo[1:0]);
      hold_reset = 1'b0;
      unique case (up)
         `IHAP_UP_CTRL: if (lo_zero) tgt = IHAP_TGT_CTRL;
         `IHAP_UP_LDM1: tgt = IHAP_TGT_LDM1;
         `IHAP_UP_LDM2: tgt = IHAP_TGT_LDM2;
         `IHAP_UP_LCMTS: tgt = IHAP_TGT_LCMTS;
         `IHAP_UP_LCMSC: tgt = IHAP_TGT_LCMSC;
         `IHAP_UP_LHOLD: hold_reset = lo_zero;
         `IHAP_UP_CDM1: if (lo_zero) tgt = IHAP_TGT_CDM1;
         `IHAP_UP_CDM2: if (lo_zero) tgt = IHAP_TGT_CDM2;
         `IHAP_UP_CCM: begin
            // Field select inside the connection block.
            if (lo == 4'h0) tgt = IHAP_TGT_CCMTS;
            else if (lo == 4'h1) tgt = IHAP_TGT_CCMSC;
            else if (lo == 4'h2) tgt = IHAP_TGT_CCMTAG;
         end
         `IHAP_UP_CCMD1: begin
            // Make, break, clear and read by the upper two bits.
            if (blk_ok) begin
               unique case (lo[3:2])
                  2'h0: op = IHAP_OP_MAKE;
                  2'h1: op = IHAP_OP_BREAK;
                  2'h2: op = IHAP_OP_CLEAR;
                  2'h3: op = IHAP_OP_READ;
               endcase
            end
         end
         `IHAP_UP_CCMD2: begin
            // Find, block reset, holding reset and initialise.
            if (lo == 4'hC) op = IHAP_OP_RSTHOLD;
            else if (lo == 4'hF) op = IHAP_OP_INIT;
            else if (blk_ok && lo[3:2] == 2'h0) op = IHAP_OP_FIND;
            else if (blk_ok && lo[3:2] == 2'h2) op = IHAP_OP_RSTBLK;
         end
         default: tgt = IHAP_TGT_NONE;
      endcase
   end
endmodule

// ==== verilog/ihap_pkg.sv ====
package ihap_pkg;
   // Memory space selected by the address mode register.
   typedef enum logic [3:0] {
      IHAP_TGT_NONE = 4'h0,
      IHAP_TGT_CTRL = 4'h1,
      IHAP_TGT_LDM1 = 4'h2,
      IHAP_TGT_LDM2 = 4'h3,
      IHAP_TGT_LCMTS = 4'h4,
      IHAP_TGT_LCMSC = 4'h5,
      IHAP_TGT_CDM1 = 4'h6,
      IHAP_TGT_CDM2 = 4'h7,
      IHAP_TGT_CCMTS = 4'h8,
      IHAP_TGT_CCMSC = 4'h9,
      IHAP_TGT_CCMTAG = 4'hA
   } ihap_tgt_t;
   // Connection-block command.
   typedef enum logic [3:0] {
      IHAP_OP_NONE = 4'h0,
      IHAP_OP_MAKE = 4'h1,
      IHAP_OP_BREAK = 4'h2,
      IHAP_OP_CLEAR = 4'h3,
      IHAP_OP_READ = 4'h4,
      IHAP_OP_FIND = 4'h5,
      IHAP_OP_RSTBLK = 4'h6,
      IHAP_OP_RSTHOLD = 4'h7,
      IHAP_OP_INIT = 4'h8
   } ihap_op_t;
   // Connection block addressed by a command.
   typedef enum logic [1:0] {
      IHAP_BLK_EVEN = 2'h0,
      IHAP_BLK_ODD = 2'h1,
      IHAP_BLK_LOCAL = 2'h3
   } ihap_blk_t;
   // Indirect access sequencer, Gray coded from IDLE through WAIT to DONE.
   typedef enum logic [1:0] {
      IHAP_ST_IDLE = 2'h0,
      IHAP_ST_WAIT = 2'h1,
      IHAP_ST_DONE = 2'h3
   } ihap_st_t;
endpackage

// ==== verilog/ihap_port.sv ====
`timescale 1ns/10ps
`include "ihap_regs.svh"
module ihap_port #(
   parameter int CLR_CYCLES = `IHAP_CLR_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Host pins.
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] addr,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // Indirect memory side.
   output ihap_pkg::ihap_tgt_t mem_sel,
   output logic [11:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_wr,
   output logic mem_rd,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   // Connection-block command side.
   output ihap_pkg::ihap_op_t cam_op,
   output ihap_pkg::ihap_blk_t cam_blk,
   output logic cam_req,
   input wire logic cam_done,
   input wire logic [7:0] cam_result,
   output logic local_hold_reset,
   // Control levels to the rest of the device.
   output logic software_reset,
   output logic clock_fault_clear,
   output logic system_fault_clear,
   output logic active_buffer,
   output logic main_bus_output_enable,
   output logic local_output_enable,
   output logic local_function_enable,
   output logic test_clock_enable
);
   import ihap_pkg::*;

   // ------------------------------------------------------------------
   // Host pin synchronisation and strobe detection.
   // ------------------------------------------------------------------
   logic [12:0] pins_s; // Synchronised host pins.
   logic cs_n_s; // Synchronised chip select.
   logic rd_n_s; // Synchronised read strobe.
   logic wr_n_s; // Synchronised write strobe.
   logic [1:0] addr_s; // Synchronised address.
   logic [7:0] din_s; // Synchronised write data.
   logic wr_n_d_r; // Write strobe one cycle later.
   logic cs_n_d_r; // Chip select one cycle later.
   logic wr_stb; // One-cycle write taken.

   ihap_sync #(.WIDTH(13), .INIT(13'h1C00)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .pin_in({cs_n, rd_n, wr_n, addr, data_in}),
      .sync_out(pins_s)
   );
   assign {cs_n_s, rd_n_s, wr_n_s, addr_s, din_s} = pins_s;

   // Delayed copies for the end-of-write edge.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_n_d_r <= 1'b1;
         cs_n_d_r <= 1'b1;
      end else begin
         wr_n_d_r <= wr_n_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   // A write is taken where the strobe rises, data being settled then.
   assign wr_stb = wr_n_s & ~wr_n_d_r & ~cs_n_d_r;

   // ------------------------------------------------------------------
   // Direct registers.
   // ------------------------------------------------------------------
   logic [7:0] mcs_r; // Master control/status, busy bit unused here.
   logic [7:0] lia_r; // Lower indirect address.
   logic [7:0] ams_r; // Address mode select.
   logic [7:0] idp_r; // Indirect data port.
   logic [7:0] mcs_nxt; // Next master control value.
   logic busy; // Connection block in use.
   logic clr_any; // Any self-clearing bit is set.
   logic clr_end; // Pulse count reached.
   logic [7:0] clr_cnt_r; // Length of the clear pulses.
   logic wr_mcs; // Write to master control.
   logic wr_lia; // Write to slot address.
   logic wr_ams; // Write to mode.
   logic wr_idp; // Write to data.

   assign wr_mcs = wr_stb && addr_s == `IHAP_ADDR_MCS;
   assign wr_lia = wr_stb && addr_s == `IHAP_ADDR_LIA;
   assign wr_ams = wr_stb && addr_s == `IHAP_ADDR_AMS;
   assign wr_idp = wr_stb && addr_s == `IHAP_ADDR_IDP;
   assign clr_any = |mcs_r[`IHAP_BIT_SWRST:`IHAP_BIT_SYSCLR];
   assign clr_end = clr_any && clr_cnt_r == 8'(CLR_CYCLES - 1);

   // Next control value: a new set wins over the self-clear.
   always_comb begin
      mcs_nxt = mcs_r;
      if (clr_end) begin
         mcs_nxt[`IHAP_BIT_SWRST:`IHAP_BIT_SYSCLR] = 3'h0;
         if (mcs_r[`IHAP_BIT_SWRST]) mcs_nxt[`IHAP_BIT_ABUF:`IHAP_BIT_LOCFN] = 4'h0;
      end
      if (wr_mcs) begin
         mcs_nxt[7:1] = din_s[7:1] | (clr_end ? 7'h00 : {mcs_r[7:5], 4'h0});
      end
      mcs_nxt[`IHAP_BIT_BUSY] = 1'b0;
   end

   // Master control register.
   always_ff @(posedge clock) begin
      if (!rst_n) mcs_r <= `IHAP_RESET_VAL;
      else mcs_r <= mcs_nxt;
   end

   // Counts the clear pulse; restarts whenever a clear bit is written.
   always_ff @(posedge clock) begin
      if (!rst_n) clr_cnt_r <= 8'h00;
      else if (wr_mcs && |din_s[7:5]) clr_cnt_r <= 8'h00;
      else if (clr_any && !clr_end) clr_cnt_r <= clr_cnt_r + 8'h01;
      else clr_cnt_r <= 8'h00;
   end

   // Slot and mode registers; a software reset returns them to zero.
   always_ff @(posedge clock) begin
      if (!rst_n || mcs_r[`IHAP_BIT_SWRST]) begin
         lia_r <= `IHAP_RESET_VAL;
         ams_r <= `IHAP_RESET_VAL;
      end else begin
         if (wr_lia) lia_r <= din_s;
         if (wr_ams) ams_r <= din_s;
      end
   end

   // ------------------------------------------------------------------
   // Mode decode of the written or current mode value.
   // ------------------------------------------------------------------
   ihap_tgt_t tgt_now; // Space of the mode in use.
   ihap_op_t op_new; // Command of a mode being written.
   ihap_blk_t blk_new; // Block of a mode being written.
   ihap_tgt_t tgt_new; // Space of a mode being written.
   logic hold_new; // Holding reset of a mode being written.
   logic [7:0] mode_eff; // Mode value to decode.

   assign mode_eff = wr_ams ? din_s : ams_r;
   ihap_mode_decode u_dec (
      .mode(mode_eff),
      .tgt(tgt_new),
      .op(op_new),
      .blk(blk_new),
      .hold_reset(hold_new)
   );
   assign tgt_now = tgt_new;

   // ------------------------------------------------------------------
   // Indirect access sequencer.
   // ------------------------------------------------------------------
   ihap_st_t st_r; // Sequencer state.
   logic is_mem; // Current space is a memory.
   logic start_rd; // Prefetch after a new selection.
   logic start_cam; // Command written.
   logic cam_wants_data; // Command returns a result.
   logic cam_pend_r; // Command in flight.

   assign is_mem = tgt_now != IHAP_TGT_NONE;
   assign start_rd = (wr_lia || wr_ams) && is_mem && !mcs_r[`IHAP_BIT_SWRST];
   assign start_cam = wr_ams && op_new != IHAP_OP_NONE && !mcs_r[`IHAP_BIT_SWRST];
   assign cam_wants_data = cam_op == IHAP_OP_READ || cam_op == IHAP_OP_FIND;
   assign busy = cam_pend_r;

   // Idle, wait for the memory or block, then one cycle to finish.
   always_ff @(posedge clock) begin
      if (!rst_n) st_r <= IHAP_ST_IDLE;
      else begin
         unique case (st_r)
            IHAP_ST_IDLE: if (start_rd || start_cam) st_r <= IHAP_ST_WAIT;
            IHAP_ST_WAIT: if ((cam_pend_r && cam_done) || (!cam_pend_r && mem_ack)) begin
               st_r <= IHAP_ST_DONE;
            end
            IHAP_ST_DONE: st_r <= IHAP_ST_IDLE;
            default: st_r <= IHAP_ST_IDLE;
         endcase
      end
   end

   // Memory address and strobes; the stream is the mode low nibble.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_sel <= IHAP_TGT_NONE;
         mem_addr <= 12'h000;
         mem_wdata <= 8'h00;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
      end else begin
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         if (st_r == IHAP_ST_IDLE && start_rd) begin
            mem_sel <= tgt_now;
            mem_addr <= {mode_eff[3:0], wr_lia ? din_s : lia_r};
            mem_rd <= 1'b1;
         end else if (st_r == IHAP_ST_IDLE && wr_idp && is_mem && !mcs_r[`IHAP_BIT_SWRST]) begin
            mem_sel <= tgt_now;
            mem_addr <= {ams_r[3:0], lia_r};
            mem_wdata <= din_s;
            mem_wr <= 1'b1;
         end
      end
   end

   // Connection-block command issue and busy flag.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cam_op <= IHAP_OP_NONE;
         cam_blk <= IHAP_BLK_EVEN;
         cam_req <= 1'b0;
         cam_pend_r <= 1'b0;
      end else begin
         cam_req <= 1'b0;
         if (st_r == IHAP_ST_IDLE && start_cam) begin
            cam_op <= op_new;
            cam_blk <= blk_new;
            cam_req <= 1'b1;
            cam_pend_r <= 1'b1;
         end else if (cam_pend_r && cam_done) begin
            cam_pend_r <= 1'b0;
         end
      end
   end

   // Local holding reset pulse on writing mode 0x70.
   always_ff @(posedge clock) begin
      if (!rst_n) local_hold_reset <= 1'b0;
      else local_hold_reset <= wr_ams && hold_new && !mcs_r[`IHAP_BIT_SWRST];
   end

   // Data register: host writes, memory prefetch and command results.
   always_ff @(posedge clock) begin
      if (!rst_n || mcs_r[`IHAP_BIT_SWRST]) idp_r <= `IHAP_RESET_VAL;
      else if (wr_idp) idp_r <= din_s;
      else if (st_r == IHAP_ST_WAIT && !cam_pend_r && mem_ack) idp_r <= mem_rdata;
      else if (cam_pend_r && cam_done && cam_wants_data) idp_r <= cam_result;
   end

   // ------------------------------------------------------------------
   // Host read path.
   // ------------------------------------------------------------------
   // Registered read data; write-only registers read as zero.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         data_oe <= ~cs_n_s & ~rd_n_s;
         unique case (addr_s)
            `IHAP_ADDR_MCS: data_out <= {mcs_r[7:1], busy};
            `IHAP_ADDR_IDP: data_out <= idp_r;
            default: data_out <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Control levels.
   // ------------------------------------------------------------------
   assign software_reset = mcs_r[`IHAP_BIT_SWRST];
   assign clock_fault_clear = mcs_r[`IHAP_BIT_CLKCLR];
   assign system_fault_clear = mcs_r[`IHAP_BIT_SYSCLR];
   assign active_buffer = mcs_r[`IHAP_BIT_ABUF];
   assign main_bus_output_enable = mcs_r[`IHAP_BIT_MAINOE] & ~software_reset;
   assign local_output_enable = mcs_r[`IHAP_BIT_LOCOE] & ~software_reset;
   assign local_function_enable = mcs_r[`IHAP_BIT_LOCFN] & ~software_reset;
   assign test_clock_enable = ~software_reset;

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   property p_decode_lia;
      @(posedge clock) disable iff (!rst_n)
      wr_lia && !mcs_r[7] |=> lia_r == $past(din_s);
   endproperty
   a_decode_lia: assert property (p_decode_lia) else $error("slot write lost");

   property p_reset_zero;
      @(posedge clock) !rst_n |=> mcs_r == 8'h00 && lia_r == 8'h00 && ams_r == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

   property p_swrst_clear;
      @(posedge clock) disable iff (!rst_n)
      mcs_r[7] && clr_end && !wr_mcs |=> !mcs_r[7] && mcs_r[4:1] == 4'h0;
   endproperty
   a_swrst_clear: assert property (p_swrst_clear) else $error("reset bit stuck");

   property p_fault_clear;
      @(posedge clock) disable iff (!rst_n)
      $rose(mcs_r[6]) |-> ##[1:256] !mcs_r[6];
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("clear bit stuck");

   property p_main_off;
      @(posedge clock) disable iff (!rst_n)
      !mcs_r[3] || mcs_r[7] |-> !main_bus_output_enable;
   endproperty
   a_main_off: assert property (p_main_off) else $error("main bus on");

   property p_test_clk;
      @(posedge clock) disable iff (!rst_n)
      test_clock_enable == !software_reset;
   endproperty
   a_test_clk: assert property (p_test_clk) else $error("test clock wrong");

   property p_busy_read;
      @(posedge clock) disable iff (!rst_n)
      (cam_req || cam_pend_r) && !cam_done |=> cam_pend_r;
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy dropped");

   property p_hold_reset;
      @(posedge clock) disable iff (!rst_n)
      wr_ams && din_s == 8'h70 && !mcs_r[7] |=> local_hold_reset && !cam_req;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("hold reset missed");

   property p_init_cmd;
      @(posedge clock) disable iff (!rst_n)
      wr_ams && din_s == 8'hFF && st_r == IHAP_ST_IDLE && !mcs_r[7]
         |=> cam_req && cam_op == IHAP_OP_INIT;
   endproperty
   a_init_cmd: assert property (p_init_cmd) else $error("init not issued");

   property p_mem_addr;
      @(posedge clock) disable iff (!rst_n)
      mem_wr |-> mem_addr == {ams_r[3:0], lia_r} && mem_wdata == idp_r;
   endproperty
   a_mem_addr: assert property (p_mem_addr) else $error("memory address wrong");
endmodule

// ==== verilog/ihap_regs.svh ====
`ifndef IHAP_REGS_SVH
`define IHAP_REGS_SVH
// ----------------------------------------------------------------------
// Host address decode of the four direct registers.
// ----------------------------------------------------------------------
`define IHAP_ADDR_MCS 2'h0
`define IHAP_ADDR_LIA 2'h1
`define IHAP_ADDR_AMS 2'h2
`define IHAP_ADDR_IDP 2'h3
// ----------------------------------------------------------------------
// Master control/status field positions.
// ----------------------------------------------------------------------
`define IHAP_BIT_SWRST 7
`define IHAP_BIT_CLKCLR 6
`define IHAP_BIT_SYSCLR 5
`define IHAP_BIT_ABUF 4
`define IHAP_BIT_MAINOE 3
`define IHAP_BIT_LOCOE 2
`define IHAP_BIT_LOCFN 1
`define IHAP_BIT_BUSY 0
// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define IHAP_RESET_VAL 8'h00
`define IHAP_CLK_MHZ 25
`define IHAP_CLR_PULSE_NS 160
`define IHAP_CLR_CYCLES ((`IHAP_CLR_PULSE_NS * `IHAP_CLK_MHZ + 999) / 1000)
// ----------------------------------------------------------------------
// Address mode upper nibble codes.
// ----------------------------------------------------------------------
`define IHAP_UP_CTRL 4'h0
`define IHAP_UP_LDM1 4'h1
`define IHAP_UP_LDM2 4'h2
`define IHAP_UP_LCMTS 4'h4
`define IHAP_UP_LCMSC 4'h5
`define IHAP_UP_LHOLD 4'h7
`define IHAP_UP_CDM1 4'h9
`define IHAP_UP_CDM2 4'hA
`define IHAP_UP_CCM 4'hB
`define IHAP_UP_CCMD1 4'hE
`define IHAP_UP_CCMD2 4'hF
`endif

// ==== verilog/ihap_sync.sv ====
`timescale 1ns/10ps
// Two-stage synchroniser for a group of pin inputs.
module ihap_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Asynchronous input and synchronised output.
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by the second.

   // Both stages load the idle level during reset.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_r <= INIT;
         sync_out <= INIT;
      end else begin
         meta_r <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule
